//--- verilog/gear_scaler.sv
// Electronic gear scaler: reference units in, encoder pulses out
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
// ------------------------------------------------------------
// How it works
// - Each reference scaled by gear ratio into pulses
// - Host pulses taken directly as reference units
// - Host doing its own scaling sets 1:1
// - Ratio num/den, 1..2^30, defaults 16/1, restart
// - Compat select picks the permitted ratio range
// - Native resolution: 0.001..64000, else error alarm
// - Reduced resolution: 0.001..4000, else error alarm
// - Rotary: resolution per load rev times m/n
// - Direct linear: travel times resolution over pitch
// - Converter: travel times converter resolution over pitch
// ------------------------------------------------------------
module gear_scaler #(
   parameter int REF_W = gear_pkg::REF_W
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Link to host
   gear_link_if.dev link,
   // Encoder pulse side
   output logic pulse_valid_o,
   output logic signed [gear_pkg::PULSE_W-1:0] pulse_delta_o,
   output logic signed [gear_pkg::PULSE_W-1:0] pulse_total_o,
   // Status
   output logic busy_o,
   output logic param_err_o
);

   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   // Product width is fixed by the 64-bit dividend
   if (REF_W != gear_pkg::REF_W) begin : g_bad_ref_w
      $error("gear_scaler: REF_W must match the link width");
   end

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   gear_pkg::scale_state_t state_r;
   logic [gear_pkg::GEAR_W-1:0] num_r;
   logic [gear_pkg::GEAR_W-1:0] den_r;
   logic compat_r;
   logic load_pend_r;
   logic apply_cfg;
   logic cfg_ok;
   logic err_r;
   logic signed [REF_W-1:0] delta_r;
   logic [gear_pkg::GEAR_W-1:0] rem_acc_r;
   logic [63:0] mag_r;
   logic [31:0] part_r;
   logic neg_r;
   logic [5:0] cnt_r;
   logic signed [63:0] total;
   logic [31:0] shifted;
   logic [gear_pkg::CHK_W-1:0] lo_prod;
   logic [gear_pkg::CHK_W-1:0] hi_lim;
   logic [gear_pkg::GEAR_W-1:0] rem_frac;
   logic signed [63:0] q_signed;
   logic [gear_pkg::GEAR_W-1:0] rem_nxt;
   logic pulse_valid_r;
   logic signed [63:0] pulse_delta_r;
   logic signed [63:0] pulse_total_r;

   // ------------------------------------------------------------
   // Gear configuration, taken after reset and at restart
   // ------------------------------------------------------------
   // Deferred until idle so a scaling in flight never sees a mixed ratio
   assign apply_cfg = load_pend_r && (state_r == gear_pkg::ST_IDLE) && !link.restart;

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         num_r <= gear_pkg::GEAR_NUM_RST;
         den_r <= gear_pkg::GEAR_DEN_RST;
         compat_r <= gear_pkg::COMPAT_RST;
         load_pend_r <= 1'b1;
      end else if (link.restart) begin
         load_pend_r <= 1'b1;
      end else if (apply_cfg) begin
         num_r <= link.gear_numerator;
         den_r <= link.gear_denominator;
         compat_r <= link.encoder_resolution_compat_select;
         load_pend_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Ratio range check
   // ------------------------------------------------------------
   always_comb begin
      lo_prod = gear_pkg::CHK_W'(num_r) * gear_pkg::CHK_W'(gear_pkg::RATIO_MIN_INV);
      if (compat_r) begin
         hi_lim = gear_pkg::CHK_W'(den_r) * gear_pkg::CHK_W'(gear_pkg::RATIO_MAX_COMPAT);
      end else begin
         hi_lim = gear_pkg::CHK_W'(den_r) * gear_pkg::CHK_W'(gear_pkg::RATIO_MAX_NATIVE);
      end
      cfg_ok = (num_r != '0) && (num_r <= gear_pkg::GEAR_MAX) && (den_r != '0) && (den_r <= gear_pkg::GEAR_MAX)
               && (lo_prod >= gear_pkg::CHK_W'(den_r)) && (gear_pkg::CHK_W'(num_r) <= hi_lim);
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         err_r <= 1'b0;
      end else begin
         err_r <= !cfg_ok;
      end
   end

   assign param_err_o = err_r;
   assign link.param_err = err_r;

   // References are refused while the ratio is illegal or a restart is pending
   // Stale alarm also refuses, so ready never shows beside a raised alarm
   assign link.ref_ready = (state_r == gear_pkg::ST_IDLE) && !load_pend_r && !link.restart && cfg_ok && !err_r;
   assign busy_o = (state_r != gear_pkg::ST_IDLE);

   // ------------------------------------------------------------
   // Datapath helpers
   // ------------------------------------------------------------
   always_comb begin
      total = 64'(delta_r) * $signed({33'h0_0000_0000, num_r}) + $signed({33'h0_0000_0000, rem_acc_r});
      shifted = {part_r[30:0], mag_r[63]};
      rem_frac = part_r[gear_pkg::GEAR_W-1:0];
      // Floor division so the remainder is always in 0..den-1
      if (neg_r && (rem_frac != '0)) begin
         q_signed = -$signed(mag_r) - 64'sh1;
         rem_nxt = den_r - rem_frac;
      end else if (neg_r) begin
         q_signed = -$signed(mag_r);
         rem_nxt = '0;
      end else begin
         q_signed = $signed(mag_r);
         rem_nxt = rem_frac;
      end
   end

   // ------------------------------------------------------------
   // Scaling sequence
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         state_r <= gear_pkg::ST_IDLE;
         delta_r <= '0;
         mag_r <= 64'h0000_0000_0000_0000;
         part_r <= 32'h0000_0000;
         neg_r <= 1'b0;
         cnt_r <= 6'h00;
      end else begin
         unique case (state_r)
            gear_pkg::ST_IDLE: begin
               if (link.ref_valid && link.ref_ready) begin
                  delta_r <= link.ref_delta;
                  state_r <= gear_pkg::ST_MUL;
               end
            end
            gear_pkg::ST_MUL: begin
               neg_r <= total[63];
               mag_r <= total[63] ? 64'(-total) : 64'(total);
               part_r <= 32'h0000_0000;
               cnt_r <= 6'h00;
               state_r <= gear_pkg::ST_DIV;
            end
            gear_pkg::ST_DIV: begin
               // One quotient bit a cycle keeps the divider small
               if (shifted >= {1'b0, den_r}) begin
                  part_r <= shifted - {1'b0, den_r};
                  mag_r <= {mag_r[62:0], 1'b1};
               end else begin
                  part_r <= shifted;
                  mag_r <= {mag_r[62:0], 1'b0};
               end
               cnt_r <= cnt_r + 6'h01;
               if (cnt_r == gear_pkg::DIV_LAST) begin
                  state_r <= gear_pkg::ST_OUT;
               end
            end
            gear_pkg::ST_OUT: begin
               state_r <= gear_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Remainder carry
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         rem_acc_r <= '0;
      end else if (apply_cfg) begin
         rem_acc_r <= '0;
      end else if (state_r == gear_pkg::ST_OUT) begin
         rem_acc_r <= rem_nxt;
      end
   end

   // ------------------------------------------------------------
   // Pulse output
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         pulse_valid_r <= 1'b0;
         pulse_delta_r <= 64'sh0;
         pulse_total_r <= 64'sh0;
      end else if (state_r == gear_pkg::ST_OUT) begin
         pulse_valid_r <= 1'b1;
         pulse_delta_r <= q_signed;
         pulse_total_r <= pulse_total_r + q_signed;
      end else begin
         pulse_valid_r <= 1'b0;
      end
   end

   assign pulse_valid_o = pulse_valid_r;
   assign pulse_delta_o = pulse_delta_r;
   assign pulse_total_o = pulse_total_r;

endmodule : gear_scaler

//--- verilog/gear_pkg.sv
// Shared constants and types for the electronic gear scaler and its host end
package gear_pkg;

   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int REF_W = 32;
   localparam int GEAR_W = 31;
   localparam int PULSE_W = 64;
   localparam int CHK_W = 48;

   // ------------------------------------------------------------
   // Gear parameter limits and reset values
   // ------------------------------------------------------------
   localparam logic [30:0] GEAR_MAX = 31'h4000_0000;
   localparam logic [30:0] GEAR_NUM_RST = 31'h0000_0010;
   localparam logic [30:0] GEAR_DEN_RST = 31'h0000_0001;
   localparam logic COMPAT_RST = 1'b0;
   // Lower bound 0.001 checked as num * 1000 >= den
   localparam logic [16:0] RATIO_MIN_INV = 17'h003E8;
   localparam logic [16:0] RATIO_MAX_NATIVE = 17'h0FA00;
   localparam logic [16:0] RATIO_MAX_COMPAT = 17'h00FA0;

   // ------------------------------------------------------------
   // Host register map (byte offsets) and fields
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_NUM = 8'h04;
   localparam logic [7:0] OFS_DEN = 8'h08;
   localparam logic [7:0] OFS_REF = 8'h0C;
   localparam logic [7:0] OFS_STAT = 8'h10;
   localparam int CTRL_RESTART_BIT = 0;
   localparam int CTRL_COMPAT_BIT = 1;
   localparam int STAT_PEND_BIT = 0;
   localparam int STAT_ERR_BIT = 1;

   // ------------------------------------------------------------
   // Scaler sequence
   // ------------------------------------------------------------
   localparam logic [5:0] DIV_LAST = 6'h3F;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_MUL = 2'b01,
      ST_DIV = 2'b11,
      ST_OUT = 2'b10
   } scale_state_t;

endpackage : gear_pkg

//--- verilog/gear_link_if.sv
// Link between the host reference issuer and the gear scaler
`timescale 1ns/1ps
interface gear_link_if;
   logic ref_valid;
   logic ref_ready;
   logic signed [gear_pkg::REF_W-1:0] ref_delta;
   logic [gear_pkg::GEAR_W-1:0] gear_numerator;
   logic [gear_pkg::GEAR_W-1:0] gear_denominator;
   logic encoder_resolution_compat_select;
   logic restart;
   logic param_err;

   modport dev (
      input ref_valid,
      input ref_delta,
      input gear_numerator,
      input gear_denominator,
      input encoder_resolution_compat_select,
      input restart,
      output ref_ready,
      output param_err
   );

   modport host (
      output ref_valid,
      output ref_delta,
      output gear_numerator,
      output gear_denominator,
      output encoder_resolution_compat_select,
      output restart,
      input ref_ready,
      input param_err
   );
endinterface : gear_link_if

//--- verilog/gear_ref_host.sv
// Host end: APB registers that configure the scaler and issue references
`timescale 1ns/1ps
module gear_ref_host (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // APB slave
   input wire logic [7:0] paddr_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Link to scaler
   gear_link_if.host link
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic [gear_pkg::GEAR_W-1:0] num_r;
   logic [gear_pkg::GEAR_W-1:0] den_r;
   logic compat_r;
   logic restart_r;
   logic signed [gear_pkg::REF_W-1:0] ref_r;
   logic pend_r;
   logic [31:0] prdata_r;
   logic hit;
   logic access;
   logic wr_done;

   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   assign hit = (paddr_i == gear_pkg::OFS_CTRL) || (paddr_i == gear_pkg::OFS_NUM) || (paddr_i == gear_pkg::OFS_DEN)
                || (paddr_i == gear_pkg::OFS_REF) || (paddr_i == gear_pkg::OFS_STAT);
   assign access = psel_i && penable_i;
   // A second reference waits in the access phase until the first is taken
   assign pready_o = !(pwrite_i && (paddr_i == gear_pkg::OFS_REF) && pend_r);
   assign pslverr_o = access && !hit;
   assign wr_done = access && pwrite_i && pready_o && hit;

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         prdata_r <= 32'h0000_0000;
      end else if (psel_i && !penable_i) begin
         unique case (paddr_i)
            gear_pkg::OFS_CTRL: prdata_r <= 32'(compat_r) << gear_pkg::CTRL_COMPAT_BIT;
            gear_pkg::OFS_NUM: prdata_r <= 32'(num_r);
            gear_pkg::OFS_DEN: prdata_r <= 32'(den_r);
            gear_pkg::OFS_REF: prdata_r <= 32'(ref_r);
            gear_pkg::OFS_STAT: prdata_r <= (32'(pend_r) << gear_pkg::STAT_PEND_BIT)
                                            | (32'(link.param_err) << gear_pkg::STAT_ERR_BIT);
            default: prdata_r <= 32'h0000_0000;
         endcase
      end
   end
   assign prdata_o = prdata_r;

   // ------------------------------------------------------------
   // Gear configuration
   // ------------------------------------------------------------
   // Defaults match the scaler; software sets 1:1 when it scales itself
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         num_r <= gear_pkg::GEAR_NUM_RST;
         den_r <= gear_pkg::GEAR_DEN_RST;
         compat_r <= gear_pkg::COMPAT_RST;
         restart_r <= 1'b0;
      end else begin
         restart_r <= wr_done && (paddr_i == gear_pkg::OFS_CTRL) && pwdata_i[gear_pkg::CTRL_RESTART_BIT];
         if (wr_done && (paddr_i == gear_pkg::OFS_CTRL)) begin
            compat_r <= pwdata_i[gear_pkg::CTRL_COMPAT_BIT];
         end
         if (wr_done && (paddr_i == gear_pkg::OFS_NUM)) begin
            num_r <= pwdata_i[gear_pkg::GEAR_W-1:0];
         end
         if (wr_done && (paddr_i == gear_pkg::OFS_DEN)) begin
            den_r <= pwdata_i[gear_pkg::GEAR_W-1:0];
         end
      end
   end

   // ------------------------------------------------------------
   // Reference issue
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         ref_r <= '0;
         pend_r <= 1'b0;
      end else if (wr_done && (paddr_i == gear_pkg::OFS_REF)) begin
         ref_r <= $signed(pwdata_i);
         pend_r <= 1'b1;
      end else if (link.ref_ready) begin
         pend_r <= 1'b0;
      end
   end

   assign link.ref_valid = pend_r;
   assign link.ref_delta = ref_r;
   assign link.gear_numerator = num_r;
   assign link.gear_denominator = den_r;
   assign link.encoder_resolution_compat_select = compat_r;
   assign link.restart = restart_r;

endmodule : gear_ref_host

//--- bench/gear_link_monitor.sv
// Concurrent checks on the link between host end and scaler
`timescale 1ns/1ps
module gear_link_monitor (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Link and scaler status
   input wire logic ref_valid,
   input wire logic ref_ready,
   input wire logic restart,
   input wire logic param_err,
   input wire logic pulse_valid_o,
   input wire logic busy_o
);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_take;
      ref_valid && ref_ready;
   endsequence

   a_answer_time: assert property (s_take |-> ##67 pulse_valid_o)
      else $error("pulse not 67 cycles after take");
   a_busy_enter: assert property (s_take |=> busy_o [*8])
      else $error("scaler not busy after take");
   a_ready_busy: assert property (busy_o |-> !ref_ready)
      else $error("ready while busy");
   a_err_refuse: assert property (param_err |-> !ref_ready)
      else $error("ready while ratio illegal");
   a_pulse_single: assert property (pulse_valid_o |=> !pulse_valid_o)
      else $error("pulse longer than one cycle");
   a_ref_hold: assert property (ref_valid && !ref_ready |=> ref_valid)
      else $error("reference dropped before taken");
   a_restart_pulse: assert property (restart |=> !restart)
      else $error("restart longer than one cycle");
   a_restart_blocks: assert property (restart |-> !ref_ready)
      else $error("ready during restart");
   a_pulse_cause: assert property (pulse_valid_o |-> $past(busy_o))
      else $error("pulse without prior scaling");
endmodule : gear_link_monitor

//--- bench/tb.sv
// Testbench joining host end and scaler, driven over APB
`timescale 1ns/1ps
module tb;
   typedef struct {
      logic [30:0] n;
      logic [30:0] d;
      logic c;
      logic [31:0] r;
      logic e;
      logic signed [63:0] p;
   } row_t;
   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic pulse_valid;
   logic signed [63:0] pulse_delta;
   logic signed [63:0] pulse_total;
   logic busy;
   logic param_err;
   logic [31:0] rdat;
   logic rerr;
   logic signed [63:0] tot0;
   int miscompares = 0;
   int compares = 0;
   row_t rows [9] = '{
      '{31'h10, 31'h1, 1'b0, 32'h2710, 1'b0, 64'sh27100},
      '{31'h1, 31'h1, 1'b0, 32'hFFFFFFFB, 1'b0, -64'sh5},
      '{31'hFA00, 31'h1, 1'b0, 32'h1, 1'b0, 64'shFA00},
      '{31'hFA01, 31'h1, 1'b0, 32'h1, 1'b1, 64'sh0},
      '{31'hFA0, 31'h1, 1'b1, 32'h2, 1'b0, 64'sh1F40},
      '{31'hFA1, 31'h1, 1'b1, 32'h1, 1'b1, 64'sh0},
      '{31'hFA00, 31'h1, 1'b1, 32'h1, 1'b1, 64'sh0},
      '{31'h1, 31'h3E8, 1'b0, 32'h9C4, 1'b0, 64'sh2},
      '{31'h1, 31'h3E9, 1'b0, 32'h1, 1'b1, 64'sh0}};

   gear_link_if lnk ();
   gear_ref_host gear_ref_host_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .paddr_i(paddr),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .link(lnk));
   gear_scaler gear_scaler_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .link(lnk),
      .pulse_valid_o(pulse_valid), .pulse_delta_o(pulse_delta), .pulse_total_o(pulse_total),
      .busy_o(busy), .param_err_o(param_err));
   gear_link_monitor gear_link_monitor_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
      .ref_valid(lnk.ref_valid), .ref_ready(lnk.ref_ready), .restart(lnk.restart),
      .param_err(lnk.param_err), .pulse_valid_o(pulse_valid), .busy_o(busy));

   initial begin
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end

   // ------------------------------------------------------------
   // Bus, wait and compare tasks
   // ------------------------------------------------------------
   // Pready and read data are taken at the rising edge that ends the access
   task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys_i);
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1'b1;
      penable <= 1'b0;
      @(posedge clk_sys_i);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys_i);
         n++;
      end while (pready !== 1'b1 && n < 300);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         miscompares++;
         final_report();
      end
   endtask : apb

   task wait_pulse();
      int n;
      n = 0;
      do begin
         @(negedge clk_sys_i);
         n++;
      end while (pulse_valid !== 1'b1 && n < 150);
      if (pulse_valid !== 1'b1) begin
         miscompares++;
         final_report();
      end
   endtask : wait_pulse

   task chk32(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk32

   task chk64(input logic signed [63:0] g, input logic signed [63:0] e);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk64

   task final_report();
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : final_report

   task load(input logic [30:0] n, input logic [30:0] d, input logic c);
      apb(gear_pkg::OFS_NUM, 1'b1, {1'b0, n});
      apb(gear_pkg::OFS_DEN, 1'b1, {1'b0, d});
      apb(gear_pkg::OFS_CTRL, 1'b1, {30'h0, c, 1'b1});
      repeat (4) @(posedge clk_sys_i);
   endtask : load

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (5) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      apb(gear_pkg::OFS_NUM, 1'b0, 32'h0);
      chk32(rdat, 32'h10);
      apb(gear_pkg::OFS_DEN, 1'b0, 32'h0);
      chk32(rdat, 32'h1);
      apb(gear_pkg::OFS_STAT, 1'b0, 32'h0);
      chk32(rdat, 32'h0);
      $display("test reset done");
      foreach (rows[i]) begin
         load(rows[i].n, rows[i].d, rows[i].c);
         apb(gear_pkg::OFS_STAT, 1'b0, 32'h0);
         chk32({31'h0, rdat[gear_pkg::STAT_ERR_BIT]}, {31'h0, rows[i].e});
         chk32({31'h0, param_err}, {31'h0, rows[i].e});
         if (rows[i].e == 1'b0) begin
            apb(gear_pkg::OFS_REF, 1'b1, rows[i].r);
            wait_pulse();
            chk64(pulse_delta, rows[i].p);
         end
         $display("test row %0d done", i);
      end
      // Second reference is written while the first is scaled; the remainder carries into it
      load(31'h1, 31'h3E8, 1'b0);
      tot0 = pulse_total;
      apb(gear_pkg::OFS_REF, 1'b1, 32'h9C4);
      apb(gear_pkg::OFS_REF, 1'b1, 32'h1F4);
      wait_pulse();
      chk64(pulse_delta, 64'sh2);
      wait_pulse();
      chk64(pulse_delta, 64'sh1);
      chk64(pulse_total - tot0, 64'sh3);
      $display("test remainder done");
      // Numerator change without restart must not alter the ratio
      apb(gear_pkg::OFS_NUM, 1'b1, 32'h7);
      apb(gear_pkg::OFS_REF, 1'b1, 32'h3E8);
      wait_pulse();
      chk64(pulse_delta, 64'sh1);
      $display("test restart needed done");
      // Mid-run reset brings back the defaults and clears the running total
      @(posedge clk_sys_i);
      rst_n_i <= 1'b0;
      repeat (5) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      apb(gear_pkg::OFS_NUM, 1'b0, 32'h0);
      chk32(rdat, 32'h10);
      chk64(pulse_total, 64'sh0);
      $display("test mid reset done");
      apb(8'h20, 1'b0, 32'h0);
      chk32(rdat, 32'h0);
      chk32({31'h0, rerr}, 32'h1);
      $display("test unmapped done");
      final_report();
   end

   initial begin
      repeat (20000) @(posedge clk_sys_i);
      miscompares++;
      final_report();
   end
endmodule : tb
